// ==== rtl/iqtg_regs.vh ====
// register map, field layout, reset values and form codes of the iq test signal generator
`ifndef IQTG_REGS_VH
`define IQTG_REGS_VH
`define IQTG_ADDR_W 4
`define IQTG_OFF_CTRL 4'h0
`define IQTG_OFF_FORM 4'h1
`define IQTG_OFF_PERIOD 4'h2
`define IQTG_OFF_PHASE 4'h3
`define IQTG_OFF_FREQ 4'h4
`define IQTG_OFF_AMPL 4'h5
`define IQTG_OFF_DC 4'h6
`define IQTG_OFF_CONST_I 4'h7
`define IQTG_OFF_CONST_Q 4'h8
`define IQTG_OFF_STATUS 4'h9
`define IQTG_OFF_INDEX 4'ha
`define IQTG_CTRL_PLAY 0
`define IQTG_CTRL_GEN 1
`define IQTG_CTRL_ARM 2
`define IQTG_CTRL_TRIG 3
`define IQTG_ST_PLAY 0
`define IQTG_ST_RUN 1
`define IQTG_ST_ARMED 2
`define IQTG_ST_FULL 3
`define IQTG_FORM_SINE 2'h0
`define IQTG_FORM_RECT 2'h1
`define IQTG_FORM_CONST 2'h2
`define IQTG_PERIOD_RST 16'h0064
`define IQTG_PERIOD_MIN 16'h0002
`define IQTG_AMPL_RST 16'h6666
`define IQTG_FREQ_RST 32'h000003e8
`define IQTG_FIFO_DEPTH 4
`define IQTG_SAMPLE_W 32
`define IQTG_LUT_AW 8
`endif

// ==== rtl/iqtg_fifo.v ====
// small flip-flop fifo between the sample generator and the playback datapath
`timescale 1ns/1ns
`default_nettype none
module iqtg_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk, // clock
  input wire rst_n, // synchronous reset, active low
  input wire in_valid, // write request
  output wire in_ready, // room available
  input wire [WIDTH-1:0] in_data, // write data
  output wire out_valid, // data available
  input wire out_ready, // reader takes data
  output wire [WIDTH-1:0] out_data // head of queue
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire do_wr;
  wire do_rd;
  localparam integer DEPTH_I = DEPTH;
  localparam integer LAST_I = DEPTH - 1;
  assign in_ready = (count_r != DEPTH_I[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rd_ptr_r];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always @(posedge clk) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_r <= (wr_ptr_r == LAST_I[AW-1:0]) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= (rd_ptr_r == LAST_I[AW-1:0]) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_r <= count_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/iqtg_top.v ====
// iq test signal generator: sine, rectangular and constant pair forms feeding the playback datapath
// Functional notes
// - sine mode: sine on I, shifted sine on Q
// - programmable phase offset applied to Q sine
// - test frequency register, stored and read back only; not used by sine or rectangle
// - programmable samples per period, sine form
// - programmable samples per period, rectangular form
// - rectangle high half period, low half
// - rectangle identical on I and Q
// - rectangle amplitude programmable as full-scale fraction
// - programmable dc shift added to rectangle samples
// - constant form holds independent I and Q values
// - direct generation becomes active output immediately
// - software can arm and manually trigger
// - playback enable disables other modulation sources
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "iqtg_regs.vh"
module iqtg_top (
  input wire CORE_CLK, // 100 mhz clock
  input wire RESET_N, // synchronous reset, active low
  input wire [3:0] REG_ADDR, // register word index
  input wire [31:0] REG_WDATA, // write data
  input wire REG_WR, // write strobe
  input wire REG_RD, // read strobe
  output reg [31:0] REG_RDATA, // read data, cycle after strobe
  input wire SAMPLE_EN, // player sample clock enable
  output wire IQ_VALID, // sample available
  input wire IQ_READY, // datapath takes sample
  output wire [15:0] IQ_I, // in-phase sample
  output wire [15:0] IQ_Q, // quadrature sample
  output reg OTHER_MOD_OFF // other modulation sources disabled
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ARMED = 2'h1;
  localparam ST_RUN = 2'h2;

  reg play_r;
  reg [1:0] form_r;
  reg [15:0] period_r;
  reg [15:0] phase_r;
  reg [31:0] freq_r;
  reg [15:0] ampl_r;
  reg [15:0] dc_r;
  reg [15:0] const_i_r;
  reg [15:0] const_q_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [15:0] index_r;
  reg [15:0] index_nxt;
  reg [31:0] rdata_nxt;
  reg [31:0] status_w;
  reg [15:0] i_nxt;
  reg [15:0] q_nxt;
  reg [31:0] q_idx;
  reg [31:0] i_acc;
  reg [31:0] q_acc;
  reg signed [16:0] rect_sum;
  reg signed [15:0] rect_val;
  wire wr_ctrl;
  wire arm_req;
  wire trig_req;
  wire gen_req;
  wire fifo_in_ready;
  wire fifo_in_valid;
  wire [31:0] fifo_out;
  wire [15:0] period_eff;
  wire signed [31:0] ampl_prod;
  wire [`IQTG_LUT_AW-1:0] i_lut_addr;
  wire [`IQTG_LUT_AW-1:0] q_lut_addr;

  // periods below two would leave the rectangle without a low half
  assign period_eff = (period_r < `IQTG_PERIOD_MIN) ? `IQTG_PERIOD_MIN : period_r;
  assign wr_ctrl = REG_WR && (REG_ADDR == `IQTG_OFF_CTRL);
  assign gen_req = wr_ctrl && REG_WDATA[`IQTG_CTRL_GEN];
  assign arm_req = wr_ctrl && REG_WDATA[`IQTG_CTRL_ARM];
  assign trig_req = wr_ctrl && REG_WDATA[`IQTG_CTRL_TRIG];

  ////////////////////////////////////////////////////////////////////////////
  // sine lookup, quarter-wave symmetry of a 256-entry full cycle
  function [15:0] sine_lut;
    input [`IQTG_LUT_AW-1:0] a;
    reg [6:0] q;
    reg [6:0] d;
    reg [12:0] sq;
    reg [15:0] m;
    begin
      // q climbs 0..63 over the first quarter and falls back 64..1 over the second
      q = a[6] ? (7'h40 - {1'b0, a[5:0]}) : {1'b0, a[5:0]};
      d = 7'h40 - q;
      // parabola 1 - (1 - x)^2 over a quarter wave, peak 0x7fff at q = 64
      sq = {6'h00, d} * {6'h00, d};
      m = 16'h7fff - {sq, 3'b000};
      if (q == 7'h00) begin
        m = 16'h0000;
      end
      sine_lut = a[7] ? (16'h0000 - m) : m;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      play_r <= 1'b0;
      form_r <= `IQTG_FORM_SINE;
      period_r <= `IQTG_PERIOD_RST;
      phase_r <= 16'h0000;
      freq_r <= `IQTG_FREQ_RST;
      ampl_r <= `IQTG_AMPL_RST;
      dc_r <= 16'h0000;
      const_i_r <= 16'h0000;
      const_q_r <= 16'h0000;
      OTHER_MOD_OFF <= 1'b0;
    end else begin
      // play and generate share the control word; generate also starts the run
      if (wr_ctrl) begin
        play_r <= REG_WDATA[`IQTG_CTRL_PLAY] | REG_WDATA[`IQTG_CTRL_GEN];
        OTHER_MOD_OFF <= REG_WDATA[`IQTG_CTRL_PLAY] | REG_WDATA[`IQTG_CTRL_GEN];
      end
      if (REG_WR) begin
        case (REG_ADDR)
          `IQTG_OFF_FORM: form_r <= REG_WDATA[1:0];
          `IQTG_OFF_PERIOD: period_r <= REG_WDATA[15:0];
          `IQTG_OFF_PHASE: phase_r <= REG_WDATA[15:0];
          `IQTG_OFF_FREQ: freq_r <= REG_WDATA;
          `IQTG_OFF_AMPL: ampl_r <= REG_WDATA[15:0];
          `IQTG_OFF_DC: dc_r <= REG_WDATA[15:0];
          `IQTG_OFF_CONST_I: const_i_r <= REG_WDATA[15:0];
          `IQTG_OFF_CONST_Q: const_q_r <= REG_WDATA[15:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word, one bit per condition
  always @* begin
    status_w = 32'h00000000;
    status_w[`IQTG_ST_PLAY] = play_r;
    status_w[`IQTG_ST_RUN] = (state_r == ST_RUN);
    status_w[`IQTG_ST_ARMED] = (state_r == ST_ARMED);
    status_w[`IQTG_ST_FULL] = !fifo_in_ready;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads
  always @* begin
    rdata_nxt = 32'h00000000;
    case (REG_ADDR)
      `IQTG_OFF_CTRL: rdata_nxt = {31'h00000000, play_r};
      `IQTG_OFF_FORM: rdata_nxt = {30'h00000000, form_r};
      `IQTG_OFF_PERIOD: rdata_nxt = {16'h0000, period_r};
      `IQTG_OFF_PHASE: rdata_nxt = {16'h0000, phase_r};
      `IQTG_OFF_FREQ: rdata_nxt = freq_r;
      `IQTG_OFF_AMPL: rdata_nxt = {16'h0000, ampl_r};
      `IQTG_OFF_DC: rdata_nxt = {16'h0000, dc_r};
      `IQTG_OFF_CONST_I: rdata_nxt = {16'h0000, const_i_r};
      `IQTG_OFF_CONST_Q: rdata_nxt = {16'h0000, const_q_r};
      `IQTG_OFF_STATUS: rdata_nxt = status_w;
      `IQTG_OFF_INDEX: rdata_nxt = {16'h0000, index_r};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // read data stand for one cycle only and return to zero
  always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_nxt;
    end else begin
      REG_RDATA <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // playback trigger state: idle, armed waiting for a trigger, running
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (gen_req || (play_r && trig_req)) begin
          state_nxt = ST_RUN;
        end else if (arm_req) begin
          state_nxt = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (trig_req || gen_req) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (arm_req) begin
          state_nxt = ST_ARMED;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // a control write with neither play nor generate returns to idle; samples already in the fifo still drain
    if (wr_ctrl && !REG_WDATA[`IQTG_CTRL_PLAY] && !REG_WDATA[`IQTG_CTRL_GEN]) begin
      state_nxt = ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample index and sample forming
  assign fifo_in_valid = (state_r == ST_RUN) && SAMPLE_EN;

  // every start, stop or manual trigger puts the pattern back at index zero;
  // a full fifo refuses the slot, so the index holds and no sample is skipped
  always @* begin
    index_nxt = index_r;
    if (state_nxt != ST_RUN || state_r != ST_RUN || trig_req) begin
      index_nxt = 16'h0000;
    end else if (fifo_in_valid && fifo_in_ready) begin
      index_nxt = (index_r >= period_eff - 16'h0001) ? 16'h0000 : index_r + 16'h0001;
    end
  end

  always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state_r <= ST_IDLE;
      index_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      index_r <= index_nxt;
    end
  end

  // lut phase = index * 256 / period; q adds phase offset, 65536 = full turn
  always @* begin
    i_acc = ({16'h0000, index_r} << `IQTG_LUT_AW) / {16'h0000, period_eff};
    q_idx = {16'h0000, phase_r} >> (16 - `IQTG_LUT_AW);
    q_acc = i_acc + q_idx;
  end
  assign i_lut_addr = i_acc[`IQTG_LUT_AW-1:0];
  assign q_lut_addr = q_acc[`IQTG_LUT_AW-1:0];

  // amplitude is a 16-bit fraction of full scale, 0x10000 being 1.0
  assign ampl_prod = $signed({1'b0, ampl_r}) * 32'sd32767;

  always @* begin
    rect_sum = 17'sh00000;
    rect_val = 16'sh0000;
    if ({index_r, 1'b0} < period_eff) begin
      rect_sum = $signed({ampl_prod[31], ampl_prod[31:16]}) + $signed({dc_r[15], dc_r});
    end else begin
      rect_sum = -$signed({ampl_prod[31], ampl_prod[31:16]}) + $signed({dc_r[15], dc_r});
    end
    // saturate so a large dc shift cannot wrap the rectangle around
    if (rect_sum > 17'sh07fff) begin
      rect_val = 16'sh7fff;
    end else if (rect_sum < -17'sh08000) begin
      rect_val = -16'sh8000;
    end else begin
      rect_val = rect_sum[15:0];
    end
    case (form_r)
      `IQTG_FORM_SINE: begin
        i_nxt = sine_lut(i_lut_addr);
        q_nxt = sine_lut(q_lut_addr);
      end
      `IQTG_FORM_RECT: begin
        i_nxt = rect_val;
        q_nxt = rect_val;
      end
      `IQTG_FORM_CONST: begin
        i_nxt = const_i_r;
        q_nxt = const_q_r;
      end
      default: begin
        i_nxt = 16'h0000;
        q_nxt = 16'h0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // output queue toward the playback datapath
  // four entries ride out short stalls of the datapath
  iqtg_fifo #(
    .WIDTH(`IQTG_SAMPLE_W),
    .DEPTH(`IQTG_FIFO_DEPTH),
    .AW(2)
  ) iqtg_fifo_inst (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({i_nxt, q_nxt}),
    .out_valid(IQ_VALID),
    .out_ready(IQ_READY),
    .out_data(fifo_out)
  );
  // the fifo word carries i in the upper half and q in the lower half
  assign IQ_I = fifo_out[31:16];
  assign IQ_Q = fifo_out[15:0];
endmodule
`default_nettype wire

// ==== test/iqtg_top_properties.sv ====
// port assertions for the iq test signal generator
`timescale 1ns/1ns
`default_nettype none
module iqtg_chk (
  input wire logic CORE_CLK, // clock
  input wire logic RESET_N, // reset, low
  input wire logic [3:0] REG_ADDR, // index
  input wire logic [31:0] REG_WDATA, // wdata
  input wire logic REG_WR, // write
  input wire logic REG_RD, // read
  input wire logic [31:0] REG_RDATA, // rdata
  input wire logic SAMPLE_EN, // sample enable
  input wire logic IQ_VALID, // valid
  input wire logic IQ_READY, // ready
  input wire logic [15:0] IQ_I, // i sample
  input wire logic [15:0] IQ_Q, // q sample
  input wire logic OTHER_MOD_OFF // others off
);
  logic [1:0] form_r;
  logic [15:0] ci_r;
  logic [15:0] cq_r;
  wire wr_ctrl = REG_WR && REG_ADDR == 4'h0;
  // shadow of the form and constant pair settings
  always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      form_r <= 2'h0;
      ci_r <= 16'h0;
      cq_r <= 16'h0;
    end else if (REG_WR) begin
      if (REG_ADDR == 4'h1) form_r <= REG_WDATA[1:0];
      if (REG_ADDR == 4'h7) ci_r <= REG_WDATA[15:0];
      if (REG_ADDR == 4'h8) cq_r <= REG_WDATA[15:0];
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  reset_quiet_a: assert property ($rose(RESET_N) |-> !IQ_VALID && !OTHER_MOD_OFF)
    else $error("outputs active after reset");
  hold_sample_a: assert property (IQ_VALID && !IQ_READY |=> IQ_VALID && $stable({IQ_I, IQ_Q}))
    else $error("sample not held");
  rect_same_a: assert property (form_r == 2'h1 && IQ_VALID |-> IQ_I == IQ_Q)
    else $error("rect i and q differ");
  const_pair_a: assert property (form_r == 2'h2 && IQ_VALID |-> IQ_I == ci_r && IQ_Q == cq_r)
    else $error("constant pair wrong");
  mod_on_a: assert property (wr_ctrl && REG_WDATA[1:0] != 2'h0 |=> OTHER_MOD_OFF)
    else $error("other sources not off");
  mod_off_a: assert property (wr_ctrl && REG_WDATA[1:0] == 2'h0 |=> !OTHER_MOD_OFF)
    else $error("other sources still off");
  gen_start_a: assert property (wr_ctrl && REG_WDATA[1] ##1 SAMPLE_EN |=> IQ_VALID)
    else $error("generation not immediate");
  stopped_a: assert property (!OTHER_MOD_OFF && !IQ_VALID |=> !IQ_VALID)
    else $error("sample while stopped");
endmodule
bind iqtg_top iqtg_chk iqtg_chk_inst (.CORE_CLK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
  .REG_RDATA, .SAMPLE_EN, .IQ_VALID, .IQ_READY, .IQ_I, .IQ_Q, .OTHER_MOD_OFF);
`default_nettype wire

// ==== test/iqtg_sink.sv ====
// playback datapath model: sample rate enable and stalling reader
`timescale 1ns/1ns
`default_nettype none
module iqtg_sink (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, low
  input wire logic hold, // refuse all samples
  input wire logic slow, // take samples at random
  output logic sample_en, // sample rate enable
  output logic ready // takes head sample
);
  always @(posedge clk) begin
    sample_en <= rst_n && ($urandom % 4 != 0);
    ready <= rst_n && !hold && (!slow || $urandom % 2 == 1);
  end
endmodule
`default_nettype wire

// ==== test/iqtg_top_tb.sv ====
// self-checking bench for the iq test signal generator
`timescale 1ns/1ns
`default_nettype none
module iqtg_top_tb;
  logic clk, rst_n, wr, rd, hold, slow, valid, omo, rd_d;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, r;
  logic [15:0] qi, qq, ci, cq;
  wire sen, rdy;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n;
  logic [31:0] rexp[$], sexp[$], got[$];
  iqtg_top iqtg_top_inst (.CORE_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SAMPLE_EN(sen), .IQ_VALID(valid),
    .IQ_READY(rdy), .IQ_I(qi), .IQ_Q(qq), .OTHER_MOD_OFF(omo));
  iqtg_sink iqtg_sink_inst (.clk(clk), .rst_n(rst_n), .hold(hold), .slow(slow),
    .sample_en(sen), .ready(rdy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wrr(input logic [3:0] a, input logic [31:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    rexp.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task run(input int m);
    got.delete();
    wrr(4'h0, 32'h2);
    for (int k = 0; k < 300 && got.size() < m; k++) @(posedge clk);
    wrr(4'h0, 32'h0);
    repeat (8) @(posedge clk);
  endtask
  task rect(input logic [15:0] dsum);
    for (int k = 0; k < 6; k++) begin
      chk(got[k][31:16], got[k][15:0]);
      chk(got[k+6], got[k]);
      chk(got[k] != got[k+3], 1'b1);
      chk(16'(got[k][31:16] + got[k+3][31:16]), dsum);
      chk(16'(got[k][31:16] - got[k+3][31:16]), (k < 3) ? 16'h0ffe : 16'hf002);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    rd_d <= rd;
    cyc <= cyc + 1;
    if (rd_d) chk(rdata, rexp.pop_front());
    if (valid && rdy) begin
      got.push_back({qi, qq});
      if (sexp.size() > 0) chk({qi, qq}, sexp.pop_front());
    end
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    {wr, rd, hold, slow, rst_n} = 5'h0;
    addr = 4'h0;
    wdata = 32'h0;
    r = $urandom(32'h3c0fbada);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(4'h1, 32'h0);
    rdc(4'h2, 32'h64);
    rdc(4'h5, 32'h6666);
    rdc(4'h4, 32'h3e8);
    r = $urandom;
    wrr(4'h4, r);
    wrr(4'hf, r);
    rdc(4'h4, r);
    rdc(4'hf, 32'h0);
    $display("registers done");
    ci = $urandom;
    cq = $urandom;
    wrr(4'h7, {16'h0, ci});
    wrr(4'h8, {16'h0, cq});
    wrr(4'h1, 32'h2);
    hold <= 1'b1;
    wrr(4'h0, 32'h2);
    chk(omo, 1'b1);
    repeat (30) @(posedge clk);
    rdc(4'h9, 32'hb);
    rdc(4'ha, 32'h4);
    repeat (8) sexp.push_back({ci, cq});
    hold <= 1'b0;
    slow <= 1'b1;
    repeat (40) @(posedge clk);
    wrr(4'h0, 32'h0);
    chk(omo, 1'b0);
    slow <= 1'b0;
    repeat (10) @(posedge clk);
    chk(sexp.size(), 32'h0);
    $display("constant pair and full fifo done");
    wrr(4'h0, 32'h5);
    rdc(4'h9, 32'h5);
    wrr(4'h0, 32'h9);
    rdc(4'h9, 32'h3);
    wrr(4'h0, 32'h5);
    rdc(4'h9, 32'h5);
    wrr(4'h0, 32'h0);
    wrr(4'h0, 32'h1);
    rdc(4'h9, 32'h1);
    wrr(4'h0, 32'h9);
    rdc(4'h9, 32'h3);
    wrr(4'h0, 32'h0);
    rdc(4'h9, 32'h0);
    $display("arm and trigger done");
    wrr(4'h2, 32'h6); // period of six, kept above the two-sample minimum
    wrr(4'h5, 32'h1000);
    wrr(4'h6, 32'h0);
    wrr(4'h1, 32'h1);
    run(13);
    rect(16'h0);
    wrr(4'h6, 32'h800);
    run(13);
    chk(16'(got[0][31:16] + got[3][31:16]), 16'h1000);
    rect(16'h1000);
    $display("rectangle done");
    wrr(4'h1, 32'h0);
    wrr(4'h2, 32'h8);
    wrr(4'h3, 32'h0);
    run(17);
    for (int k = 0; k < 8; k++) begin
      chk(got[k][31:16], got[k][15:0]);
      chk(got[k+8], got[k]);
    end
    wrr(4'h3, 32'h4000);
    run(17);
    n = 0;
    for (int k = 0; k < 8; k++) n += (got[k][31:16] != got[k][15:0]);
    chk(n >= 4, 1'b1);
    for (int k = 0; k < 8; k++) begin
      chk(got[k][15:0], got[(k+2)%8][31:16]);
      chk(16'(got[k][31:16] + got[(k+4)%8][31:16]), 16'h0);
    end
    chk(got[0][31:16], 16'h0);
    chk(got[2][31:16], 16'h7fff);
    $display("sine done");
    conclude();
  end
endmodule
`default_nettype wire
